// ===== dv/gpe_checker.sv
/* Assertions on the ports of gpe_port.
   Assumes the bench leaves pin 0 uninverted and never gives it sense code 7. */
`timescale 1ns/10ps
module gpe_checker import gpe_pkg::*; #(
    parameter int unsigned PINS = 8,
    parameter int unsigned CHANNELS = 8
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic [PINS-1:0] pin_i,
    input wire logic [PINS-1:0] pin_o,
    input wire logic [PINS-1:0] pin_oe_o,
    input wire logic [PINS-1:0] slew_limit_o,
    input wire gpe_override_t override_i,
    input wire logic [CHANNELS-1:0] channel_i,
    input wire gpe_event_t event_o,
    input wire logic [1:0] irq0_priority_o,
    input wire logic [1:0] irq1_priority_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // Plain writes with no peripheral holding the pins.
    sequence s_way_wr;
        wr_i && addr_i == OFS_PIN_WAY && override_i.enable == 8'h00;
    endsequence
    sequence s_level_wr;
        wr_i && addr_i == OFS_DRIVE_LEVEL && override_i.enable == 8'h00;
    endsequence
    property p_way;
        s_way_wr |-> ##2 pin_oe_o[3:0] == $past(wdata_i[3:0], 2);
    endproperty
    a_way: assert property (p_way) else $error("direction write missed the enables");
    property p_level;
        s_level_wr |-> ##2 (!pin_oe_o[0] || pin_o[0] == $past(wdata_i[0], 2));
    endproperty
    a_level: assert property (p_level) else $error("level write missed the pin");
    // The fields reach the outputs one edge after the register takes the write.
    property p_prio;
        wr_i && addr_i == OFS_PORT_IRQ_PRIORITY |-> ##2
            (irq0_priority_o == $past(wdata_i[1:0], 2) && irq1_priority_o == $past(wdata_i[3:2], 2));
    endproperty
    a_prio: assert property (p_prio) else $error("priority fields not copied");
    property p_upper;
        rd_i && addr_i == OFS_PORT_IRQ_PRIORITY |=> rdata_o[7:4] == 4'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper priority bits not zero");
    property p_slew;
        $changed(slew_limit_o) |-> $past(wr_i) || $past(wr_i, 2);
    endproperty
    a_slew: assert property (p_slew) else $error("slew limit moved without a write");
    property p_takeover;
        override_i.enable[0] && $stable(override_i) |=>
            pin_o[0] == $past(override_i.level[0]) && pin_oe_o[0] == $past(override_i.way[0]);
    endproperty
    a_takeover: assert property (p_takeover) else $error("override did not take pin 0");
    // A fresh signal event needs a sampled pin change, barring any write in the three cycles before.
    property p_edge;
        $rose(event_o.signal[0]) && !$past(wr_i) && !$past(wr_i, 2) && !$past(wr_i, 3)
            |-> $past(pin_i[0], 3) != $past(pin_i[0], 4);
    endproperty
    a_edge: assert property (p_edge) else $error("event without a sampled change");
    property p_data;
        event_o.data[0] == $past(pin_i[0], 3);
    endproperty
    a_data: assert property (p_data) else $error("data event does not carry the pin");
endmodule
bind gpe_port gpe_checker #(.PINS(PINS), .CHANNELS(CHANNELS)) i_gpe_checker (.clock_i, .rst_b_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_i, .pin_o, .pin_oe_o, .slew_limit_o,
    .override_i, .channel_i, .event_o, .irq0_priority_o, .irq1_priority_o);

// ===== dv/gpe_pins_model.sv
/* Pads of the port: each follows the port's drive while enabled, else the outside level.
   Assumes no pull resistor, so an undriven pad shows only what the outside drives. */
`timescale 1ns/10ps
module gpe_pins_model (
    input wire logic [7:0] pin_o_i,
    input wire logic [7:0] pin_oe_i,
    input wire logic [7:0] ext_i,
    output logic [7:0] pad_o
);
    assign pad_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
endmodule

// ===== dv/gpio_port_events_regs_test.sv
/* Self-checking bench for gpe_port with the pad model.
   Assumes the checker is bound to the port and a 125 MHz clock. */
`timescale 1ns/10ps
module gpio_port_events_regs_test;
    import gpe_pkg::*;
    logic clock_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0;
    logic [5:0] addr_i = 0;
    logic [7:0] wdata_i = 0, ext = 0, channel_i = 0, rdata_o, pin_i, pin_o, pin_oe_o, slew_limit_o;
    gpe_override_t override_i = '0;
    gpe_event_t event_o;
    logic [1:0] irq0_priority_o, irq1_priority_o;
    int n_mismatch = 0, check_count = 0, cyc = 0;
    gpe_port i_gpe_port (.clock_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_i,
        .pin_o, .pin_oe_o, .slew_limit_o, .override_i, .channel_i, .event_o, .irq0_priority_o,
        .irq1_priority_o);
    gpe_pins_model i_gpe_pins_model (.pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .ext_i(ext), .pad_o(pin_i));
    initial begin
        forever #4 clock_i = ~clock_i;
    end
    // A hang is cut short well past the couple of hundred cycles the run needs.
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, e);
    endtask
    // Counts high samples of an event signal (sel 0) or a pin drive (sel 1).
    task automatic count(input int n, input bit sel, input int k, input int e);
        int c;
        c = 0;
        repeat (n) begin
            tick(1);
            c += sel ? pin_o[k] : event_o.signal[k];
        end
        check(8'(c), 8'(e));
    endtask
    task automatic t_alias();
        logic [5:0] b;
        rd(OFS_PIN_WAY, RESET_BYTE);
        rd(OFS_DRIVE_LEVEL, RESET_BYTE);
        for (int i = 0; i < 2; i++) begin
            b = i ? OFS_DRIVE_LEVEL : OFS_PIN_WAY;
            wr(b, 8'h5a);
            wr(b + 6'h1, 8'h81);
            rd(b + 6'h1, 8'hdb);
            wr(b + 6'h2, 8'h0b);
            rd(b + 6'h2, 8'hd0);
            wr(b + 6'h3, 8'hff);
            rd(b + 6'h3, 8'h2f);
        end
        check(pin_oe_o, 8'h2f);
        wr(OFS_DRIVE_LEVEL, 8'h05);
        tick(2);
        check(pin_o & pin_oe_o, 8'h05);
        wr(OFS_PIN_WAY, 8'h00);
    endtask
    task automatic t_irq();
        wr(OFS_PORT_IRQ_PRIORITY, 8'h0e);
        rd(OFS_PORT_IRQ_PRIORITY, 8'h0e);
        check({4'h0, irq1_priority_o, irq0_priority_o}, 8'h0e);
        wr(OFS_PORT_IRQ_PRIORITY, 8'h00);
        tick(2);
        check({4'h0, irq1_priority_o, irq0_priority_o}, 8'h00);
    endtask
    task automatic t_input_group();
        @(posedge clock_i);
        ext <= 8'ha4;
        tick(3);
        rd(OFS_PIN_LEVEL, 8'ha4);
        wr(OFS_PIN_SETUP_BASE + 6'h2, 8'h07);
        rd(OFS_PIN_LEVEL, 8'ha0);
        ext <= 8'h00;
        wr(OFS_GROUP_CONFIG_SELECT, 8'h30);
        wr(OFS_PIN_SETUP_BASE + 6'h4, 8'h80);
        tick(2);
        check(slew_limit_o, 8'h30);
        wr(OFS_PIN_SETUP_BASE + 6'h4, 8'h00);
        tick(2);
        check(slew_limit_o, 8'h20);
    endtask
    task automatic t_events();
        logic [2:0] s [3] = '{SENSE_RISE, SENSE_FALL, SENSE_BOTH};
        int up [3] = '{1, 0, 1};
        int dn [3] = '{0, 1, 1};
        for (int i = 0; i < 3; i++) begin
            wr(OFS_PIN_SETUP_BASE, {5'h00, s[i]});
            @(posedge clock_i);
            ext[0] <= 1'b1;
            count(6, 0, 0, up[i]);
            check({7'h00, event_o.data[0]}, 8'h01);
            @(posedge clock_i);
            ext[0] <= 1'b0;
            count(6, 0, 0, dn[i]);
        end
        wr(OFS_PIN_SETUP_BASE, {5'h00, SENSE_LEVEL});
        @(posedge clock_i);
        ext[0] <= 1'b1;
        tick(4);
        count(6, 0, 0, 6);
        @(posedge clock_i);
        ext[0] <= 1'b0;
        tick(4);
        count(6, 0, 0, 0);
        wr(OFS_PIN_SETUP_BASE + 6'h1, 8'h43);
        tick(4);
        count(6, 0, 1, 6);
    endtask
    task automatic t_override_vport();
        @(posedge clock_i);
        override_i <= '{enable: 8'h01, way: 8'h01, level: 8'h01};
        tick(2);
        check({6'h00, pin_oe_o[0], pin_o[0]}, 8'h03);
        rd(OFS_PIN_WAY, 8'h00);
        @(posedge clock_i);
        override_i <= '0;
        wr(OFS_VPORT_BASE + 6'h1, 8'h3c);
        rd(OFS_DRIVE_LEVEL, 8'h3c);
        wr(OFS_VPORT_BASE + 6'hc, 8'h0f);
        rd(OFS_PIN_WAY, 8'h0f);
        // A window whose map names another port must leave this port alone.
        wr(OFS_VPORT_MAP, 8'h40);
        wr(OFS_VPORT_BASE + 6'hc, 8'h55);
        rd(OFS_PIN_WAY, 8'h0f);
        wr(OFS_PIN_WAY, 8'h80);
    endtask
    task automatic t_clock_out();
        logic a;
        wr(OFS_SIGNAL_OUTPUT_SELECT, 8'hf8);
        tick(3);
        a = pin_o[7];
        tick(1);
        check({7'h00, pin_o[7]}, {7'h00, ~a});
        wr(OFS_SIGNAL_OUTPUT_SELECT, 8'hba);
        tick(3);
        fork
            begin
                @(posedge clock_i);
                channel_i <= 8'h04;
                @(posedge clock_i);
                channel_i <= 8'h00;
            end
            count(6, 1, 7, 1);
        join
    endtask
    initial begin
        repeat (16) @(posedge clock_i);
        rst_b_i <= 1'b1;
        tick(3);
        t_alias();
        t_irq();
        t_input_group();
        t_events();
        t_override_vport();
        t_clock_out();
        print_verdict();
    end
endmodule

// ===== hw/gpe_pkg.sv
/*
 * Package for the eight-pin general-purpose I/O port with events.
 * Holds register offsets, field positions, reset values, sense codes and the
 * packed carriers shared by the port and its bench. Assumes byte registers on
 * a plain address/strobe port with read data one cycle after the read strobe.
 */
package gpe_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [5:0] OFS_PIN_WAY = 6'h00;
    localparam logic [5:0] OFS_PIN_WAY_SET = 6'h01;
    localparam logic [5:0] OFS_PIN_WAY_CLEAR = 6'h02;
    localparam logic [5:0] OFS_PIN_WAY_FLIP = 6'h03;
    localparam logic [5:0] OFS_DRIVE_LEVEL = 6'h04;
    localparam logic [5:0] OFS_DRIVE_LEVEL_SET = 6'h05;
    localparam logic [5:0] OFS_DRIVE_LEVEL_CLEAR = 6'h06;
    localparam logic [5:0] OFS_DRIVE_LEVEL_FLIP = 6'h07;
    localparam logic [5:0] OFS_PIN_LEVEL = 6'h08;
    localparam logic [5:0] OFS_PORT_IRQ_PRIORITY = 6'h09;
    localparam logic [5:0] OFS_SIGNAL_OUTPUT_SELECT = 6'h0a;
    localparam logic [5:0] OFS_GROUP_CONFIG_SELECT = 6'h0b;
    localparam logic [5:0] OFS_VPORT_MAP = 6'h0c;
    localparam logic [5:0] OFS_VPORT_BASE = 6'h20;
    localparam logic [5:0] OFS_PIN_SETUP_BASE = 6'h10;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned SETUP_SLEW_BIT = 7;
    localparam int unsigned SETUP_INVERT_BIT = 6;
    localparam int unsigned SETUP_SENSE_LSB = 0;
    localparam int unsigned IRQ1_LSB = 2;
    localparam int unsigned IRQ0_LSB = 0;
    localparam logic [7:0] IRQ_PRIORITY_MASK = 8'h0f;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int unsigned SELECT_ENABLE_BIT = 7;
    localparam int unsigned SELECT_CLOCK_BIT = 6;
    localparam int unsigned SELECT_PIN_LSB = 3;
    localparam int unsigned SELECT_CHAN_LSB = 0;

    // ------------------------------------------------------------------
    // Sense codes
    // ------------------------------------------------------------------
    localparam logic [2:0] SENSE_BOTH = 3'h0;
    localparam logic [2:0] SENSE_RISE = 3'h1;
    localparam logic [2:0] SENSE_FALL = 3'h2;
    localparam logic [2:0] SENSE_LEVEL = 3'h3;
    localparam logic [2:0] SENSE_OFF = 3'h7;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] enable;  // Peripheral takes the pin.
        logic [7:0] way;     // Direction wanted by the peripheral.
        logic [7:0] level;   // Value wanted by the peripheral.
    } gpe_override_t;

    typedef struct packed {
        logic [7:0] signal;  // Sense-shaped event per pin.
        logic [7:0] data;    // Pin value per pin.
    } gpe_event_t;

endpackage

// ===== hw/gpe_port.sv
/*
 * Eight-pin general-purpose I/O port: direction and level registers with
 * set/clear/flip aliases, synchronised input, per-pin setup, multi-pin
 * configuration, virtual port windows, event outputs and clock/event output.
 * Assumes a single 125 MHz clock and a bus master that never waits.
 */
`timescale 1ns/10ps

// Behaviour
// - Pin events only from clocked logic
// - Edge events after one clock sample
// - Level sense: high pin events every cycle
// - Signal event per sense, data event pin
// - Peripheral override takes pin when enabled
// - Override controls never software visible
// - Independent slew limit enable per pin
// - Clock or event channel onto chosen pin
// - One setup write updates all masked pins
// - Four virtual ports act like real registers
// - Direction register, one means output, resets zero
// - Direction set writes ones, reads direction
// - Direction clear writes ones, reads direction
// - Direction flip writes ones, reads direction
// - Output level drives pin only when output
// - Level set writes ones, reads level
// - Level clear writes ones, reads level
// - Level flip writes ones, reads level
// - Input register shows level unless disabled
// - Two two-bit interrupt priority fields
// - Pin value passes two-stage synchroniser
// - Group mask clears after setup write
module gpe_port #(
    parameter int unsigned PINS = 8,
    parameter int unsigned CHANNELS = 8
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [gpe_pkg::ADDR_W-1:0] addr_i,
    input wire logic [gpe_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [gpe_pkg::DATA_W-1:0] rdata_o,
    input wire logic [PINS-1:0] pin_i,
    output logic [PINS-1:0] pin_o,
    output logic [PINS-1:0] pin_oe_o,
    output logic [PINS-1:0] slew_limit_o,
    input wire gpe_pkg::gpe_override_t override_i,
    input wire logic [CHANNELS-1:0] channel_i,
    output gpe_pkg::gpe_event_t event_o,
    output logic [1:0] irq0_priority_o,
    output logic [1:0] irq1_priority_o
);
    import gpe_pkg::*;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------

    // Two-stage reset release; assertion is immediate, release is clocked.
    logic rst_meta_b;
    logic rst_b;

    // The reset copy leaves reset two edges after the pin goes high.
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_b <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_b <= rst_meta_b;
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [PINS-1:0] pin_way;           // One per pin: output when set.
    logic [PINS-1:0] drive_level;       // Level driven on output pins.
    logic [7:0] port_irq_priority_reg;  // Two priority fields, low nibble.
    logic [7:0] signal_output_select;   // Clock or event channel routing.
    logic [PINS-1:0] group_config_select;  // Multi-pin setup mask.
    logic [7:0] pin_setup [PINS];       // Per-pin slew, invert and sense.
    logic [7:0] vport_map;              // Two bits per virtual window.
    logic [PINS-1:0] sync_meta;         // First synchroniser stage.
    logic [PINS-1:0] pin_level;         // Second stage; input register.
    logic [PINS-1:0] pin_level_prev;    // Previous sample for edges.
    logic [PINS-1:0] sense_off;         // Input buffer disabled per pin.
    logic [PINS-1:0] seen;              // Inversion applied to samples.
    logic [PINS-1:0] seen_prev;
    logic [5:0] eff_addr;               // Address after virtual mapping.
    logic eff_hit;                      // Address decodes to a register.

    // ------------------------------------------------------------------
    // Virtual port windows
    // ------------------------------------------------------------------

    // Virtual window decode.
    // Each of four windows of four bytes maps onto the direction, level, input
    // and priority offsets when its map bits equal this port's number, which is zero.
    // Only direction, level, input and priority registers are mirrored; that keeps
    // the bit-access window small at the cost of no setup access.
    always_comb begin
        eff_addr = addr_i;
        eff_hit = 1'b1;
        if (addr_i >= OFS_VPORT_BASE) begin
            if (vport_map[addr_i[3:2]*2 +: 2] == 2'h0) begin
                case (addr_i[1:0])
                    2'h0: eff_addr = OFS_PIN_WAY;
                    2'h1: eff_addr = OFS_DRIVE_LEVEL;
                    2'h2: eff_addr = OFS_PIN_LEVEL;
                    default: eff_addr = OFS_PORT_IRQ_PRIORITY;
                endcase
            end else begin
                eff_hit = 1'b0;
            end
            if (addr_i[4]) begin
                eff_hit = 1'b0;
            end
        end
    end

    // Write strobe that reached a real register.
    function automatic logic wr_at(input logic [5:0] ofs, input logic [5:0] a, input logic hit, input logic wr);
        wr_at = wr && hit && (a == ofs);
    endfunction

    // ------------------------------------------------------------------
    // Direction register
    // ------------------------------------------------------------------

    // Plain write, then set, clear and flip aliases acting on ones only.
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            pin_way <= RESET_BYTE[PINS-1:0];
        end else if (wr_at(OFS_PIN_WAY, eff_addr, eff_hit, wr_i)) begin
            pin_way <= wdata_i[PINS-1:0];
        end else if (wr_at(OFS_PIN_WAY_SET, eff_addr, eff_hit, wr_i)) begin
            pin_way <= pin_way | wdata_i[PINS-1:0];
        end else if (wr_at(OFS_PIN_WAY_CLEAR, eff_addr, eff_hit, wr_i)) begin
            pin_way <= pin_way & ~wdata_i[PINS-1:0];
        end else if (wr_at(OFS_PIN_WAY_FLIP, eff_addr, eff_hit, wr_i)) begin
            pin_way <= pin_way ^ wdata_i[PINS-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Output level register
    // ------------------------------------------------------------------

    // Same alias scheme as the direction register.
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            drive_level <= RESET_BYTE[PINS-1:0];
        end else if (wr_at(OFS_DRIVE_LEVEL, eff_addr, eff_hit, wr_i)) begin
            drive_level <= wdata_i[PINS-1:0];
        end else if (wr_at(OFS_DRIVE_LEVEL_SET, eff_addr, eff_hit, wr_i)) begin
            drive_level <= drive_level | wdata_i[PINS-1:0];
        end else if (wr_at(OFS_DRIVE_LEVEL_CLEAR, eff_addr, eff_hit, wr_i)) begin
            drive_level <= drive_level & ~wdata_i[PINS-1:0];
        end else if (wr_at(OFS_DRIVE_LEVEL_FLIP, eff_addr, eff_hit, wr_i)) begin
            drive_level <= drive_level ^ wdata_i[PINS-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------

    // Priority (low nibble only kept), routing select and virtual map; read/write bytes.
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            port_irq_priority_reg <= RESET_BYTE;
            signal_output_select <= RESET_BYTE;
            vport_map <= RESET_BYTE;
        end else begin
            if (wr_at(OFS_PORT_IRQ_PRIORITY, eff_addr, eff_hit, wr_i)) begin
                port_irq_priority_reg <= wdata_i & IRQ_PRIORITY_MASK;
            end
            if (wr_at(OFS_SIGNAL_OUTPUT_SELECT, eff_addr, eff_hit, wr_i)) begin
                signal_output_select <= wdata_i;
            end
            if (wr_at(OFS_VPORT_MAP, eff_addr, eff_hit, wr_i)) begin
                vport_map <= wdata_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin setup and multi-pin mask
    // ------------------------------------------------------------------

    // A setup write lands on its own pin, or on every masked pin when the
    // mask is non-zero; the mask then clears itself.
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            group_config_select <= RESET_BYTE[PINS-1:0];
            for (int i = 0; i < PINS; i++) begin
                pin_setup[i] <= RESET_BYTE;
            end
        end else if (wr_i && eff_hit && eff_addr[5:3] == OFS_PIN_SETUP_BASE[5:3]) begin
            for (int i = 0; i < PINS; i++) begin
                if ((group_config_select != '0) ? group_config_select[i] : (eff_addr[2:0] == i[2:0])) begin
                    pin_setup[i] <= wdata_i;
                end
            end
            group_config_select <= '0;
        end else if (wr_at(OFS_GROUP_CONFIG_SELECT, eff_addr, eff_hit, wr_i)) begin
            group_config_select <= wdata_i[PINS-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Input synchroniser and sense
    // ------------------------------------------------------------------

    // Disabled-input and inversion views of the setup array.
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            sense_off[i] = (pin_setup[i][SETUP_SENSE_LSB +: 3] == SENSE_OFF);
            seen[i] = pin_level[i] ^ pin_setup[i][SETUP_INVERT_BIT];
            seen_prev[i] = pin_level_prev[i] ^ pin_setup[i][SETUP_INVERT_BIT];
        end
    end

    // Two-stage synchroniser.
    // Disabled pins are not sampled: both stages hold at zero for them.
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            sync_meta <= '0;
            pin_level <= '0;
            pin_level_prev <= '0;
        end else begin
            sync_meta <= pin_i & ~sense_off;
            pin_level <= sync_meta & ~sense_off;
            pin_level_prev <= pin_level;
        end
    end

    // Sense-shaped events, registered so each lasts one whole cycle.
    // Edges compare two clocked samples, so nothing fires without a clock.
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            event_o <= '0;
        end else begin
            for (int i = 0; i < PINS; i++) begin
                event_o.data[i] <= seen[i];
                case (pin_setup[i][SETUP_SENSE_LSB +: 3])
                    SENSE_BOTH: event_o.signal[i] <= seen[i] ^ seen_prev[i];
                    SENSE_RISE: event_o.signal[i] <= seen[i] & ~seen_prev[i];
                    SENSE_FALL: event_o.signal[i] <= ~seen[i] & seen_prev[i];
                    SENSE_LEVEL: event_o.signal[i] <= seen[i];
                    default: event_o.signal[i] <= 1'b0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------

    // Override wires come only from peripherals; no register reads them.
    // The clock output uses the registered enable to gate a toggle copy,
    // since a flop output cannot carry the clock itself; it runs at half
    // rate, which is the limitation traded for a glitch-free pin.
    logic clock_copy;
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            clock_copy <= 1'b0;
        end else begin
            clock_copy <= ~clock_copy;
        end
    end

    // Drive, enable and slew registered straight to the pins.
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            pin_o <= '0;
            pin_oe_o <= '0;
            slew_limit_o <= '0;
        end else begin
            for (int i = 0; i < PINS; i++) begin
                slew_limit_o[i] <= pin_setup[i][SETUP_SLEW_BIT];
                if (override_i.enable[i]) begin
                    pin_o[i] <= override_i.level[i];
                    pin_oe_o[i] <= override_i.way[i];
                end else if (signal_output_select[SELECT_ENABLE_BIT]
                             && signal_output_select[SELECT_PIN_LSB +: 3] == i[2:0]) begin
                    pin_o[i] <= signal_output_select[SELECT_CLOCK_BIT] ? clock_copy
                              : channel_i[signal_output_select[SELECT_CHAN_LSB +: 3]];
                    pin_oe_o[i] <= 1'b1;
                end else begin
                    pin_o[i] <= (drive_level[i] ^ pin_setup[i][SETUP_INVERT_BIT]) & pin_way[i];
                    pin_oe_o[i] <= pin_way[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt priority outputs and read path
    // ------------------------------------------------------------------

    // Fields go out registered; zero means the interrupt is disabled.
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            irq0_priority_o <= 2'h0;
            irq1_priority_o <= 2'h0;
        end else begin
            irq0_priority_o <= port_irq_priority_reg[IRQ0_LSB +: 2];
            irq1_priority_o <= port_irq_priority_reg[IRQ1_LSB +: 2];
        end
    end

    // Read data for one cycle after the strobe; zero otherwise or unmapped.
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            rdata_o <= '0;
        end else if (rd_i && eff_hit) begin
            case (eff_addr)
                OFS_PIN_WAY, OFS_PIN_WAY_SET, OFS_PIN_WAY_CLEAR, OFS_PIN_WAY_FLIP:
                    rdata_o <= 8'(pin_way);
                OFS_DRIVE_LEVEL, OFS_DRIVE_LEVEL_SET, OFS_DRIVE_LEVEL_CLEAR, OFS_DRIVE_LEVEL_FLIP:
                    rdata_o <= 8'(drive_level);
                OFS_PIN_LEVEL: rdata_o <= 8'(pin_level);
                OFS_PORT_IRQ_PRIORITY: rdata_o <= port_irq_priority_reg;
                OFS_SIGNAL_OUTPUT_SELECT: rdata_o <= signal_output_select;
                OFS_GROUP_CONFIG_SELECT: rdata_o <= 8'(group_config_select);
                OFS_VPORT_MAP: rdata_o <= vport_map;
                default: begin
                    if (eff_addr[5:3] == OFS_PIN_SETUP_BASE[5:3]) begin
                        rdata_o <= pin_setup[eff_addr[2:0]];
                    end else begin
                        rdata_o <= '0;
                    end
                end
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

endmodule
